// ==== hw/wt_tick_sync.sv ====
// synchroniser and rising-edge tick for the 32.768 kHz input
`timescale 1ns/100ps
`include "wt_timer_params.svh"

module wt_tick_sync
	import wt_timer_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// slow clock pin
	input  wire logic osc_32k,
	// one-cycle tick on each rising edge
	output logic      tick_ff
);

	wt_sync_type q_ff;
	wt_sync_type nxt_q;

	// ==========================================================
	// three-stage sync, level moves when stages two and three agree
	always_comb begin
		nxt_q = q_ff;
		nxt_q.stage = {q_ff.stage[1:0], osc_32k};
		nxt_q.tick = 1'b0;
		if (q_ff.stage[1] == q_ff.stage[2] &&
		    q_ff.stage[2] != q_ff.level) begin
			nxt_q.level = q_ff.stage[2];
			nxt_q.tick = q_ff.stage[2];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign tick_ff = q_ff.tick;

endmodule

// ==== hw/wt_timer_params.svh ====
// constants, offsets and reset values of the week timer
`ifndef WT_TIMER_PARAMS_SVH
`define WT_TIMER_PARAMS_SVH

// ==========================================================
// register offsets
`define WT_OFS_SECS     8'h04
`define WT_OFS_THRESH   8'h08
`define WT_OFS_PRESC    8'h0C
`define WT_OFS_SEL      8'h10

// ==========================================================
// reset values and fixed values
`define WT_RST_SECS     28'h0000000
`define WT_RST_THRESH   28'h0FFFFFF
`define WT_RST_SEL      4'h0
`define WT_PRESC_ZERO   15'h0000
`define WT_PRESC_ONE    15'h0001
`define WT_PRESC_FULL   15'h7FFF
`define WT_SEL_OFF      4'h0
`define WT_SEL_MAX      4'hF
`define WT_SECS_MSB     27
`define WT_SEL_MSB      3
`define WT_RDATA_ZERO   32'h00000000
`define WT_PAD_SECS     4'h0
`define WT_PAD_PRESC    17'h00000
`define WT_PAD_SEL      28'h0000000

`endif

// ==== hw/wt_timer_pkg.sv ====
// types shared by the week timer modules
package wt_timer_pkg;

	typedef logic [14:0] wt_presc_type;
	typedef logic [27:0] wt_secs_type;
	typedef logic [3:0]  wt_sel_type;

	typedef struct packed {
		logic [2:0] stage;
		logic       level;
		logic       tick;
	} wt_sync_type;

	typedef struct packed {
		wt_presc_type presc;
		wt_secs_type  secs;
		wt_secs_type  thresh;
		wt_sel_type   sel;
		logic         alarm;
		logic         powerup;
		logic         frac;
		logic [31:0]  rdata;
		logic         rvalid;
	} wt_state_type;

endpackage

// ==== hw/wt_week_timer.sv ====
// week timer: prescaler, seconds count, alarm and sub-second events
`timescale 1ns/100ps
`include "wt_timer_params.svh"

module wt_week_timer
	import wt_timer_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// slow clock pin and run control
	input  wire logic        osc_32k,
	input  wire logic        count_run_bit,
	// register port
	input  wire logic        bus_req,
	input  wire logic        bus_wr,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	output logic      [31:0] bus_rdata_ff,
	output logic             bus_rvalid_ff,
	// events
	output logic             week_alarm_irq_ff,
	output logic             week_powerup_evt_ff,
	output logic             fraction_tick_evt_ff
);

	wt_state_type q_ff;
	wt_state_type nxt_q;
	logic         tick;
	logic         wr_secs;
	logic         wr_thresh;
	logic         wr_sel;
	logic         rd_presc;

	// ==========================================================
	// slow clock tick
	wt_tick_sync u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.osc_32k  (osc_32k),
		.tick_ff  (tick)
	);

	// ==========================================================
	// helpers
	function automatic logic fraction_hit(
		input wt_sel_type   sel,
		input wt_presc_type p
	);
		wt_presc_type mask;
		mask = `WT_PRESC_FULL >> sel;
		fraction_hit = (sel != `WT_SEL_OFF) &&
		               ((p & mask) == `WT_PRESC_ZERO);
	endfunction

	function automatic logic [31:0] read_mux(
		input logic [7:0]   addr,
		input wt_state_type s
	);
		read_mux = `WT_RDATA_ZERO;
		unique case (addr)
			`WT_OFS_SECS:   read_mux = {`WT_PAD_SECS, s.secs};
			`WT_OFS_THRESH: read_mux = {`WT_PAD_SECS, s.thresh};
			`WT_OFS_PRESC:  read_mux = {`WT_PAD_PRESC, s.presc};
			`WT_OFS_SEL:    read_mux = {`WT_PAD_SEL, s.sel};
			default:        read_mux = `WT_RDATA_ZERO;
		endcase
	endfunction

	assign wr_secs   = bus_req && bus_wr && bus_addr == `WT_OFS_SECS;
	assign wr_thresh = bus_req && bus_wr && bus_addr == `WT_OFS_THRESH;
	assign wr_sel    = bus_req && bus_wr && bus_addr == `WT_OFS_SEL;
	assign rd_presc  = bus_req && !bus_wr && bus_addr == `WT_OFS_PRESC;

	// ==========================================================
	// next state
	always_comb begin
		nxt_q = q_ff;
		nxt_q.frac = 1'b0;
		nxt_q.rvalid = 1'b0;
		if (!count_run_bit) begin
			nxt_q.presc = `WT_PRESC_ZERO;
		end else if (tick) begin
			nxt_q.presc = wt_presc_type'(q_ff.presc + `WT_PRESC_ONE);
			if (q_ff.presc == `WT_PRESC_ZERO) begin
				nxt_q.secs = wt_secs_type'(q_ff.secs + 1'b1);
			end
			nxt_q.frac = fraction_hit(q_ff.sel, nxt_q.presc);
		end
		// writes to secs, thresh and sel apply at once, any run state; prescaler writes are ignored
		if (wr_secs) begin
			nxt_q.secs = bus_wdata[`WT_SECS_MSB:0];
		end
		if (wr_thresh) begin
			nxt_q.thresh = bus_wdata[`WT_SECS_MSB:0];
		end
		if (wr_sel) begin
			nxt_q.sel = bus_wdata[`WT_SEL_MSB:0];
		end
		if (bus_req && !bus_wr) begin
			nxt_q.rvalid = 1'b1;
			nxt_q.rdata = read_mux(bus_addr, q_ff);
		end
		nxt_q.alarm = nxt_q.secs >= nxt_q.thresh;
		nxt_q.powerup = nxt_q.secs >= nxt_q.thresh;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q_ff <= '{presc: `WT_PRESC_ZERO, secs: `WT_RST_SECS,
			          thresh: `WT_RST_THRESH, sel: `WT_RST_SEL,
			          alarm: 1'b0, powerup: 1'b0, frac: 1'b0,
			          rdata: `WT_RDATA_ZERO, rvalid: 1'b0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign bus_rdata_ff         = q_ff.rdata;
	assign bus_rvalid_ff        = q_ff.rvalid;
	assign week_alarm_irq_ff    = q_ff.alarm;
	assign week_powerup_evt_ff  = q_ff.powerup;
	assign fraction_tick_evt_ff = q_ff.frac;

	// ==========================================================
	// checks
	presc_hold_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!count_run_bit |=> q_ff.presc == `WT_PRESC_ZERO)
		else $error("prescaler not held at zero");

	secs_step_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		count_run_bit && tick && q_ff.presc == `WT_PRESC_ZERO &&
		!wr_secs |=> q_ff.secs == wt_secs_type'($past(q_ff.secs) + 1'b1))
		else $error("seconds did not step");

	secs_at_one_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$changed(q_ff.secs) && !$past(wr_secs)
		|-> q_ff.presc == `WT_PRESC_ONE)
		else $error("seconds stepped off the 0 to 1 edge");

	secs_hold_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!count_run_bit && !wr_secs |=> $stable(q_ff.secs))
		else $error("seconds moved while stopped");

	alarm_level_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		week_alarm_irq_ff == (q_ff.secs >= q_ff.thresh) &&
		week_powerup_evt_ff == week_alarm_irq_ff)
		else $error("alarm does not follow compare");

	presc_read_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		rd_presc |=> bus_rvalid_ff &&
		bus_rdata_ff == {`WT_PAD_PRESC, $past(q_ff.presc)})
		else $error("prescaler read wrong");

	frac_off_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		q_ff.sel == `WT_SEL_OFF |=> !fraction_tick_evt_ff)
		else $error("sub-second event while disabled");

	frac_full_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		q_ff.sel == `WT_SEL_MAX && count_run_bit && tick
		|=> fraction_tick_evt_ff ##1 !fraction_tick_evt_ff)
		else $error("fastest sub-second event missing");

	thresh_write_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		wr_thresh |=> q_ff.thresh == $past(bus_wdata[`WT_SECS_MSB:0]))
		else $error("threshold write lost");

	secs_write_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		wr_secs |=> q_ff.secs == $past(bus_wdata[`WT_SECS_MSB:0]))
		else $error("seconds write lost");

	sel_write_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		wr_sel |=> q_ff.sel == $past(bus_wdata[`WT_SEL_MSB:0]))
		else $error("rate select write lost");

	read_pulse_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		bus_req && !bus_wr |=> bus_rvalid_ff)
		else $error("read answer missing");

	no_read_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!(bus_req && !bus_wr) |=> !bus_rvalid_ff)
		else $error("read answer without a read");

	secs_read_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		bus_req && !bus_wr && bus_addr == `WT_OFS_SECS
		|=> bus_rdata_ff == {`WT_PAD_SECS, $past(q_ff.secs)})
		else $error("seconds read wrong");

	presc_step_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		count_run_bit && tick |=> q_ff.presc ==
		wt_presc_type'($past(q_ff.presc) + `WT_PRESC_ONE))
		else $error("prescaler did not step");

	presc_still_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		count_run_bit && !tick |=> $stable(q_ff.presc))
		else $error("prescaler moved without a tick");

	frac_align_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		fraction_tick_evt_ff |-> (q_ff.presc &
		(`WT_PRESC_FULL >> $past(q_ff.sel))) == `WT_PRESC_ZERO)
		else $error("sub-second event off the rate boundary");

	frac_single_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		fraction_tick_evt_ff |=> !fraction_tick_evt_ff)
		else $error("sub-second event longer than one cycle");

	frac_stopped_a: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!count_run_bit |=> !fraction_tick_evt_ff)
		else $error("sub-second event while stopped");

endmodule

// ==== sim/wt_osc_model.sv ====
// slow clock source model, sped up to keep runs short
`timescale 1ns/100ps

// ==========================================================
// free-running slow clock
module wt_osc_model #(parameter int HALF_NS = 500) (
	// slow clock out
	output logic osc_32k
);
	initial osc_32k = 1'b0;
	always #(HALF_NS) osc_32k = ~osc_32k;
endmodule

// ==== sim/wt_week_timer_test.sv ====
// self-checking bench of the week timer
`timescale 1ns/100ps
`include "wt_timer_params.svh"

module wt_week_timer_test;
	import wt_timer_pkg::*;
	logic        core_clk = 0;
	logic        reset_n = 0;
	logic        run = 0;
	logic        req = 0;
	logic        wr = 0;
	logic [7:0]  addr = 0;
	logic [31:0] wdata = 0;
	logic [31:0] seed = 98;
	logic [31:0] d;
	logic [31:0] q[$];
	logic [31:0] rdata;
	logic        osc_32k, rvalid, alarm, pwr, frac;
	int          num_errors = 0;
	int          num_checks = 0;
	int          nfrac = 0;
	int          sels[9] = '{0, 1, 9, 10, 11, 12, 13, 14, 15};
	wt_secs_type secs, thr;

	// ==========================================================
	// clock, far side and block
	always #25 core_clk = ~core_clk;
	wt_osc_model osc (.osc_32k(osc_32k));
	wt_week_timer uut (.core_clk(core_clk), .reset_n(reset_n),
		.osc_32k(osc_32k), .count_run_bit(run), .bus_req(req),
		.bus_wr(wr), .bus_addr(addr), .bus_wdata(wdata),
		.bus_rdata_ff(rdata), .bus_rvalid_ff(rvalid),
		.week_alarm_irq_ff(alarm), .week_powerup_evt_ff(pwr),
		.fraction_tick_evt_ff(frac));

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] v);
		@(posedge core_clk) #1;
		req = 1;
		wr = w;
		addr = a;
		wdata = v;
		@(posedge core_clk) #1;
		req = 0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		q.push_back(e);
		bus(0, a, 32'h0);
	endtask
	task automatic ticks(int n);
		int k;
		repeat (n) begin
			k = 0;
			while (osc_32k !== 1'b0 && k < 100) begin
				@(posedge core_clk);
				k++;
			end
			while (osc_32k !== 1'b1 && k < 100) begin
				@(posedge core_clk);
				k++;
			end
			if (k >= 100) begin
				num_errors++;
				report_and_stop();
			end
		end
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	// ==========================================================
	// output watcher
	always @(negedge core_clk) begin
		if (rvalid === 1'b1 && q.size() == 0) check(q.size(), 32'h1);
		else if (rvalid === 1'b1) check(rdata, q.pop_front());
		if (frac === 1'b1) nfrac++;
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		num_errors++;
		report_and_stop();
	end

	// ==========================================================
	// scenarios
	initial begin
		repeat (6) @(posedge core_clk);
		#1 reset_n = 1;
		rd(`WT_OFS_SECS, 32'h0);
		rd(`WT_OFS_THRESH, 32'h0FFFFFF);
		rd(`WT_OFS_PRESC, 32'h0);
		rd(`WT_OFS_SEL, 32'h0);
		rd(8'h14, 32'h0);
		check(32'(alarm), 32'h0);
		$display("test reset done");
		repeat (4) begin
			secs = wt_secs_type'(xs());
			thr = wt_secs_type'(xs());
			d = xs();
			bus(1, `WT_OFS_SECS, {4'hF, secs});
			bus(1, `WT_OFS_THRESH, {4'hF, thr});
			bus(1, `WT_OFS_SEL, d);
			bus(1, `WT_OFS_PRESC, xs());
			rd(`WT_OFS_SECS, {4'h0, secs});
			rd(`WT_OFS_THRESH, {4'h0, thr});
			rd(`WT_OFS_SEL, {28'h0, d[3:0]});
			rd(`WT_OFS_PRESC, 32'h0);
			check(32'(alarm), 32'(secs >= thr));
			check(32'(pwr), 32'(secs >= thr));
		end
		bus(1, `WT_OFS_THRESH, {4'h0, secs});
		check(32'(alarm), 32'h1);
		bus(1, `WT_OFS_THRESH, {4'h0, secs + 28'h1});
		check(32'(alarm), 32'h0);
		$display("test registers done");
		bus(1, `WT_OFS_SECS, 32'h5);
		bus(1, `WT_OFS_THRESH, 32'h7);
		ticks(1);
		run = 1;
		ticks(1);
		rd(`WT_OFS_SECS, 32'h6);
		rd(`WT_OFS_PRESC, 32'h1);
		ticks(3);
		rd(`WT_OFS_SECS, 32'h6);
		rd(`WT_OFS_PRESC, 32'h4);
		run = 0;
		rd(`WT_OFS_PRESC, 32'h0);
		ticks(2);
		rd(`WT_OFS_SECS, 32'h6);
		run = 1;
		ticks(1);
		rd(`WT_OFS_SECS, 32'h7);
		check(32'(alarm), 32'h1);
		$display("test counting done");
		for (int i = 0; i < 9; i++) begin
			run = 0;
			bus(1, `WT_OFS_SEL, 32'(sels[i]));
			ticks(1);
			run = 1;
			nfrac = 0;
			ticks(64);
			check(nfrac, sels[i] == 0 ? 0 : 64 >> (15 - sels[i]));
		end
		$display("test rates done");
		check(q.size(), 32'h0);
		report_and_stop();
	end
endmodule
